/* File: tb/rvm_regulator_monitor_tb.sv */
/*
 Self-checking bench for the regulator output voltage monitor.
 Assumes rvm_pkg and the monitor are compiled first; the bench answers conversions.
*/
`timescale 1ns/1ns
module rvm_regulator_monitor_tb;
	// ==========================================================
	// Stimulus and observed signals
	localparam int HOLD = 15000;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [10:0] rail_on = 11'h000;
	logic [10:0] watch = 11'h000;
	logic [10:0][7:0] nom = '0;
	logic mask = 1'b0;
	logic rst_sel = 1'b0;
	logic fb2_sel = 1'b0;
	logic deb = 1'b0;
	logic [7:0] blank = 8'h00;
	logic [10:0] retarget = 11'h000;
	logic ev_clr = 1'b0;
	logic man_req = 1'b0;
	logic [3:0] man_chan = 4'h0;
	logic adc_done = 1'b0;
	logic [9:0] adc_data = 10'h000;
	logic [7:0] v8 = 8'h00;
	logic [7:0] v9 = 8'h00;
	logic [7:0] v10 = 8'h00;
	logic [1:0] lsb = 2'h0;
	logic [9:0] man_val = 10'h000;
	logic [10:0] shut_acc = 11'h000;
	logic [10:0] shut_snap;
	int pend = 0;
	int starts = 0;
	int start_snap;
	int n8 = 0;
	int n8_goal = 0;
	int num_errors = 0;
	int cmp_count = 0;
	logic adc_start;
	logic [3:0] adc_chan;
	logic ev;
	logic irq_n;
	logic [10:0] shut;
	logic rst_n;
	logic good;
	logic fb2;
	logic [7:0] res8;
	logic [7:0] res9;
	logic [7:0] res10;
	logic [2:0] idx8;
	logic [1:0] r_lo;
	logic [7:0] r_hi;
	logic c_rdy;

	rvm_regulator_monitor #(.RST_HOLD_CYC(HOLD)) u_rvm_regulator_monitor (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.regmon_mode_select(mode), .eco_mode(1'b0), .rail_on(rail_on),
		.rail_watch_en(watch), .rail_nominal(nom), .rail_slewing(11'h000),
		.rail_retarget(retarget), .window_blank_delay(blank),
		.window_debounce_sel(deb), .rail_window_irq_mask(mask),
		.fail_reset_select(rst_sel), .fb2_good_sel(fb2_sel), .event_clear(ev_clr),
		.man_req(man_req), .man_chan(man_chan), .adc_done(adc_done),
		.adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan),
		.adc_rail(), .rail_window_event(ev), .irq_out_n(irq_n),
		.rail_shutdown(shut), .system_reset_out_n(rst_n), .rails_good_flag(good),
		.feedback_pin_two(fb2), .chan8_watch_result(res8), .chan9_watch_result(res9),
		.chan10_watch_result(res10), .chan8_fail_index(idx8), .chan9_fail_index(),
		.chan10_fail_index(), .conv_result_low(r_lo), .conv_result_high(r_hi),
		.conv_ready(c_rdy)
	);

	always #50 ref_clk = ~ref_clk;

	// ==========================================================
	// Converter stand-in; data line toggles while idle
	function automatic logic [7:0] vsel(input logic [3:0] c);
		return (c == 4'h8) ? v8 : (c == 4'h9) ? v9 : v10;
	endfunction

	always @(negedge ref_clk) begin
		if (adc_start === 1'b1) begin
			pend <= 3;
			starts <= starts + 1;
		end else if (pend == 1) begin
			pend <= 0;
		end else if (pend > 1) begin
			pend <= pend - 1;
		end
		adc_done <= (pend == 1 && adc_start !== 1'b1);
		if (pend == 1 && adc_start !== 1'b1) begin
			adc_data <= (adc_chan == 4'h4) ? man_val : {vsel(adc_chan), lsb};
		end else begin
			adc_data <= ~adc_data;
		end
		if (adc_done === 1'b1 && adc_chan == 4'h8) begin
			n8 <= n8 + 1;
		end
		shut_acc <= shut_acc | shut;
	end

	// ==========================================================
	// Checking helpers
	function automatic logic [7:0] up(input logic [7:0] n);
		return n + (n >> 3);
	endfunction

	function automatic logic [7:0] lo(input logic [7:0] n);
		return n - (n >> 3);
	endfunction

	task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return ev;
			1: return rst_n;
			2: return good;
			3: return c_rdy;
			default: return n8 >= n8_goal;
		endcase
	endfunction

	// Bounded wait; running out counts as a mismatch
	task automatic wait_for(input int w, input logic val, input int max);
		int n;
		n = 0;
		while (pick(w) !== val && n < max) begin
			@(negedge ref_clk);
			n++;
		end
		chk("wait_done", {10'h000, val}, {10'h000, pick(w)});
		// One more edge: accumulators fed by the stand-in settle after this one
		@(negedge ref_clk);
	endtask

	task automatic clear_event();
		ev_clr = 1'b1;
		@(negedge ref_clk);
		ev_clr = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic print_verdict();
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		// Scenarios need about 82,000 cycles
		repeat (95000) @(posedge ref_clk);
		num_errors++;
		print_verdict();
	end

	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(47646));
		nom[0] = 8'h40 + 8'($urandom % 64);
		nom[5] = 8'h40 + 8'($urandom % 64);
		nom[8] = 8'h40 + 8'($urandom % 64);
		lsb = 2'($urandom % 4);
		man_val = 10'($urandom % 1024);
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		@(negedge ref_clk);
		chk("event", 0, ev);
		chk("irq_n", 1, irq_n);
		chk("reset_n", 1, rst_n);
		chk("idx8", 0, idx8);
		// Debounced supervision: first hit must not raise the event
		mode = 2'h1;
		deb = 1'b1;
		rail_on = 11'h121;
		watch = 11'h021;
		v8 = up(nom[0]) + 8'h01 + 8'($urandom % 16);
		v9 = nom[5];
		v10 = nom[8];
		n8_goal = 1;
		wait_for(4, 1'b1, 12000);
		repeat (3) @(negedge ref_clk);
		chk("event", 0, ev);
		wait_for(0, 1'b1, 12000);
		chk("res8", v8, res8);
		chk("idx8", 1, idx8);
		chk("irq_n", 0, irq_n);
		chk("shut0", 1, shut_acc[0]);
		chk("shut5", 0, shut_acc[5]);
		chk("res9", rvm_pkg::RES_RST, res9);
		clear_event();
		chk("event", 0, ev);
		chk("idx8", 0, idx8);
		chk("res8", v8, res8);
		// Masked: reset output, lower threshold, hold time; retarget blanks one pass
		mask = 1'b1;
		rst_sel = 1'b1;
		deb = 1'b0;
		v8 = lo(nom[0]) - 8'h01 - 8'($urandom % 8);
		shut_snap = shut_acc;
		blank = 8'h02;
		retarget = 11'h001;
		@(negedge ref_clk);
		retarget = 11'h000;
		n8_goal = n8 + 1;
		wait_for(4, 1'b1, 12000);
		chk("reset_n", 1, rst_n);
		wait_for(1, 1'b0, 12000);
		chk("res8", v8, res8);
		chk("irq_n", 1, irq_n);
		chk("event", 1, ev);
		v8 = nom[0];
		repeat (HOLD - 2000) @(negedge ref_clk);
		chk("reset_n", 0, rst_n);
		wait_for(1, 1'b1, 3000);
		chk("shut", shut_snap, shut_acc);
		fb2_sel = 1'b1;
		wait_for(2, 1'b1, 12000);
		@(negedge ref_clk);
		chk("fb2", 1, fb2);
		watch[8] = 1'b1;
		rail_on[8] = 1'b0;
		wait_for(2, 1'b0, 12000);
		// Measurement-only: event per result, no shutdown, pause
		rail_on[8] = 1'b1;
		mode = 2'h2;
		mask = 1'b0;
		v8 = up(nom[0]) + 8'h02;
		// Only A8 watched, so the first result after the clear is from A8
		watch = 11'h001;
		clear_event();
		shut_snap = shut_acc;
		wait_for(0, 1'b1, 12000);
		chk("res8", v8, res8);
		start_snap = starts;
		repeat (10000) @(negedge ref_clk);
		chk("starts", 0, 11'(starts - start_snap));
		chk("shut", shut_snap, shut_acc);
		// Burst: next A8 rail picked up, event only once the A10 slot ends
		mode = 2'h3;
		mask = 1'b1;
		v10 = 8'($urandom % 256);
		rail_on = 11'h123;
		watch = 11'h102;
		n8_goal = n8 + 1;
		wait_for(4, 1'b1, 12000);
		chk("idx8", 2, idx8);
		clear_event();
		chk("event", 0, ev);
		wait_for(0, 1'b1, 12000);
		chk("res10", v10, res10);
		chk("res8", v8, res8);
		// Manual conversion with auto measurement off
		mode = 2'h0;
		watch = 11'h000;
		man_chan = 4'h4;
		man_req = 1'b1;
		@(negedge ref_clk);
		man_req = 1'b0;
		wait_for(3, 1'b1, 12000);
		chk("conv_hi", man_val[9:2], r_hi);
		chk("conv_lo", man_val[1:0], r_lo);
		print_verdict();
	end
endmodule

/* File: verilog/rvm_pkg.sv */
/*
 Constants for the regulator output voltage monitor: scheduler timing,
 channel to regulator mapping, mode codes and reset values.
 Assumes a 10 MHz core clock feeding the monitor.
*/
package rvm_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 10;
	localparam int SLOT_US = 100;
	localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
	localparam int SLOTS = 10;
	localparam int HS_PERIOD_MS = 1;
	localparam int ECO_PERIOD_MS = 10;
	localparam int ECO_RATIO = ECO_PERIOD_MS / HS_PERIOD_MS;
	localparam int RST_HOLD_MS = 1;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000 * CLK_MHZ;
	localparam int RST_CNT_W = 16;
	// ==========================================================
	// Slots and channels
	localparam logic [3:0] SLOT_A8 = 4'h1;
	localparam logic [3:0] SLOT_A9 = 4'h4;
	localparam logic [3:0] SLOT_A10 = 4'h7;
	localparam logic [3:0] SLOT_LAST = 4'h9;
	localparam logic [3:0] MUX_A8 = 4'h8;
	localparam int NRAIL = 11;
	localparam int NCH = 3;
	// Rails 0-4: core1, core2, pro, ldo3, ldo11; 5-7: io, mem, peri; 8-10: ldo7-9
	localparam int CH_BASE [NCH] = '{0, 5, 8};
	localparam int CH_SIZE [NCH] = '{5, 3, 3};
	// ==========================================================
	// Window and reset values
	localparam int MARGIN_SHIFT = 3;
	localparam logic [7:0] RES_RST = 8'h00;
	localparam logic [2:0] IDX_RST = 3'h0;
	localparam logic [7:0] BLANK_RST = 8'h00;
	typedef enum logic [1:0] {RVM_OFF, RVM_SUPERVISE, RVM_MEAS_ONLY, RVM_BURST} rvm_mode_t;
endpackage

/* File: verilog/rvm_regulator_monitor.sv */
/*
 Regulator output voltage monitor: slot scheduler, per-channel round robin,
 window check, event, shutdown, reset and power-good outputs, manual result.
 Assumes an external converter answering adc_start with one adc_done pulse
 within the same slot, and a power manager acting on rail_shutdown.
*/
`timescale 1ns/1ns
// Functional notes
// - Supervision mode disables a monitored rail found outside its window, except when masked with reset selected.
// - Each rail has its own watch enable; rails grouped on channels A8, A9, A10.
// - Enabled watched rails measured every 1 ms, or 10 ms in economy mode.
// - Upper and lower thresholds follow the rail's current nominal target.
// - Out of range stores result, rail index, and sets the window event.
// - Comparisons blanked after switch-on, while slewing, and after retargeting.
// - With debounce, two consecutive hits on the same threshold are needed.
// - Several rails on one channel are measured in turn, lengthening each period.
// - Monitoring continues after an event; fields hold the latest failure.
// - Clearing the event resets the index fields.
// - Masked interrupt: reset-select picks shutdown or reset output.
// - Reset output held at least 1 ms and until rail back in range.
// - Power-good only while all watched rails in range; disabled rail blocks it.
// - Measurement-only mode sets the event on every A8-A10 result.
// - Burst mode sets the event when the A10 slot ends.
// - Measurement modes do no comparison and no shutdown.
// - Unmasked pending event in measurement modes pauses A8-A10 and keeps results.
// - Manual conversion delivers 10 bits split into low and high results.
// - Scheduler cycles through ten 100 us slots; A8, A9, A10 own a slot each.
// - Automatic results keep only the eight MSBs.
module rvm_regulator_monitor #(
	parameter int RST_HOLD_CYC = rvm_pkg::RST_HOLD_CYC
) (
	input wire logic ref_clk, // Core clock
	input wire logic sys_rst, // Async reset
	input wire logic clk_en, // Freezes all state when low
	input wire logic [1:0] regmon_mode_select, // Off, supervise, meas-only, burst
	input wire logic eco_mode, // Economy: one sequence in ten
	input wire logic [10:0] rail_on, // Rail enabled by power manager
	input wire logic [10:0] rail_watch_en, // Bit 0 core_buck1_watch_en, 4 linear11_watch_en
	input wire logic [10:0][7:0] rail_nominal, // Nominal target, result scale
	input wire logic [10:0] rail_slewing, // Rail voltage slewing
	input wire logic [10:0] rail_retarget, // Active voltage written or A/B swapped
	input wire logic [7:0] window_blank_delay, // Blanking, in sequences
	input wire logic window_debounce_sel, // Two-hit debounce
	input wire logic rail_window_irq_mask, // Interrupt mask
	input wire logic fail_reset_select, // Masked: 1 reset, 0 shutdown
	input wire logic fb2_good_sel, // Route power-good to pin while interrupt masked
	input wire logic event_clear, // Host clear pulse
	input wire logic man_req, // Manual conversion request pulse
	input wire logic [3:0] man_chan, // Manual mux channel
	input wire logic adc_done, // Conversion done pulse
	input wire logic [9:0] adc_data, // Conversion data
	output logic adc_start, // Conversion start pulse
	output logic [3:0] adc_chan, // Mux channel
	output logic [3:0] adc_rail, // Rail connected to channel
	output logic rail_window_event, // Sticky event
	output logic irq_out_n, // Interrupt, low active
	output logic [10:0] rail_shutdown, // Shutdown pulses
	output logic system_reset_out_n, // Reset, low active
	output logic rails_good_flag, // All watched rails in range
	output logic feedback_pin_two, // Pin carrying power-good
	output logic [7:0] chan8_watch_result, // A8 result
	output logic [7:0] chan9_watch_result, // A9 result
	output logic [7:0] chan10_watch_result, // A10 result
	output logic [2:0] chan8_fail_index, // A8 rail index plus one
	output logic [2:0] chan9_fail_index, // A9 rail index plus one
	output logic [2:0] chan10_fail_index, // A10 rail index plus one
	output logic [1:0] conv_result_low, // Manual LSBs
	output logic [7:0] conv_result_high, // Manual MSBs
	output logic conv_ready // Manual result pulse
);
	// ==========================================================
	// Round robin pick: {found, local index} of next eligible after p
	function automatic logic [3:0] rvm_pick(input logic [4:0] m, input logic [2:0] p,
		input int n);
		logic [3:0] r;
		logic [2:0] j;
		r = 4'h0;
		for (int i = 5; i >= 1; i--) begin
			j = 3'((int'(p) + i) % n);
			if (i <= n && m[j])
				r = {1'b1, j};
		end
		return r;
	endfunction

	// ==========================================================
	// State
	rvm_pkg::rvm_mode_t mode;
	logic [9:0] slot_cyc, next_slot_cyc;
	logic [3:0] slot, next_slot, seq, next_seq;
	logic busy, next_busy, busy_auto, next_busy_auto, man_pend, next_man_pend;
	logic [1:0] busy_ch, next_busy_ch;
	logic [2:0] busy_loc, next_busy_loc;
	logic [2:0][2:0] ptr, next_ptr, idx, next_idx;
	logic [2:0][7:0] res, next_res;
	logic next_event, next_adc_start, next_conv_ready, next_good, next_fb2;
	logic [3:0] next_adc_chan, next_adc_rail;
	logic [10:0] prev_hi, next_prev_hi, prev_lo, next_prev_lo, oor, next_oor;
	logic [10:0] next_shut, rail_on_q, blanked;
	logic [rvm_pkg::RST_CNT_W-1:0] rst_cnt, next_rst_cnt;
	logic rst_hold, next_rst_hold;
	logic [1:0] next_man_lo;
	logic [7:0] next_man_hi;
	logic slot_end, slot_start, active, base_tick, meas_mode, paused, ev_set, fail;
	logic [10:0] elig;

	assign mode = rvm_pkg::rvm_mode_t'(regmon_mode_select);
	assign slot_end = slot_cyc == 10'(rvm_pkg::SLOT_CYC - 1);
	assign slot_start = slot_cyc == 10'h000;
	assign active = !eco_mode || seq == 4'h0;
	assign base_tick = slot_end && slot == rvm_pkg::SLOT_LAST && active;
	assign meas_mode = mode == rvm_pkg::RVM_MEAS_ONLY || mode == rvm_pkg::RVM_BURST;
	assign paused = meas_mode && rail_window_event && !rail_window_irq_mask;
	assign elig = rail_watch_en & rail_on;
	assign irq_out_n = !(rail_window_event && !rail_window_irq_mask);
	assign system_reset_out_n = !rst_hold;
	assign {chan10_watch_result, chan9_watch_result, chan8_watch_result} = res;
	assign {chan10_fail_index, chan9_fail_index, chan8_fail_index} = idx;

	// ==========================================================
	// Blanking, one counter per rail, counted in sequences
	for (genvar r = 0; r < rvm_pkg::NRAIL; r++) begin : g_blank
		logic [7:0] cnt, next_cnt;
		always_comb begin
			next_cnt = cnt;
			if ((rail_on[r] && !rail_on_q[r]) || rail_slewing[r] || rail_retarget[r])
				next_cnt = window_blank_delay;
			else if (base_tick && cnt != 8'h00)
				next_cnt = cnt - 8'h01;
		end
		always_ff @(posedge ref_clk or posedge sys_rst) begin
			if (sys_rst)
				cnt <= rvm_pkg::BLANK_RST;
			else if (clk_en)
				cnt <= next_cnt;
		end
		assign blanked[r] = cnt != 8'h00;
	end

	// ==========================================================
	// Scheduler, checks and responses
	always_comb begin
		logic [1:0] ch;
		logic [3:0] pk, g;
		logic [7:0] v, nom;
		logic [8:0] up, lo_th;
		logic hi, lo, auto_slot, man_slot, meas_done;
		ch = 2'd0;
		pk = 4'h0;
		g = adc_rail;
		v = adc_data[9:2];
		nom = rail_nominal[g];
		up = {1'b0, nom} + 9'(nom >> rvm_pkg::MARGIN_SHIFT);
		lo_th = {1'b0, nom} - 9'(nom >> rvm_pkg::MARGIN_SHIFT);
		hi = {1'b0, v} > up;
		lo = {1'b0, v} < lo_th;
		meas_done = 1'b0;
		fail = 1'b0;
		ev_set = 1'b0;
		auto_slot = 1'b1;
		man_slot = 1'b0;
		next_slot_cyc = slot_end ? 10'h000 : slot_cyc + 10'h001;
		next_slot = slot;
		next_seq = seq;
		if (slot_end) begin
			next_slot = slot == rvm_pkg::SLOT_LAST ? 4'h0 : slot + 4'h1;
			if (slot == rvm_pkg::SLOT_LAST)
				next_seq = seq == 4'(rvm_pkg::ECO_RATIO - 1) ? 4'h0 : seq + 4'h1;
		end
		case (slot)
			rvm_pkg::SLOT_A8: ch = 2'd0;
			rvm_pkg::SLOT_A9: ch = 2'd1;
			rvm_pkg::SLOT_A10: ch = 2'd2;
			4'h2, 4'h5, 4'h8: begin
				auto_slot = 1'b0;
				man_slot = 1'b1;
			end
			default: auto_slot = 1'b0;
		endcase
		pk = rvm_pick(5'(elig >> rvm_pkg::CH_BASE[ch]) & 5'((1 << rvm_pkg::CH_SIZE[ch]) - 1),
			ptr[ch], rvm_pkg::CH_SIZE[ch]);
		next_busy = busy;
		next_busy_auto = busy_auto;
		next_busy_ch = busy_ch;
		next_busy_loc = busy_loc;
		next_ptr = ptr;
		next_adc_start = 1'b0;
		next_adc_chan = adc_chan;
		next_adc_rail = adc_rail;
		next_man_pend = man_req || man_pend;
		if (slot_start && !busy) begin
			if (auto_slot && active && !paused && mode != rvm_pkg::RVM_OFF && pk[3]) begin
				next_adc_start = 1'b1;
				next_adc_chan = rvm_pkg::MUX_A8 + 4'(ch);
				next_adc_rail = 4'(rvm_pkg::CH_BASE[ch]) + {1'b0, pk[2:0]};
				next_busy = 1'b1;
				next_busy_auto = 1'b1;
				next_busy_ch = ch;
				next_busy_loc = pk[2:0];
				next_ptr[ch] = pk[2:0];
			end else if (man_slot && man_pend) begin
				next_adc_start = 1'b1;
				next_adc_chan = man_chan;
				next_busy = 1'b1;
				next_busy_auto = 1'b0;
				next_man_pend = man_req;
			end
		end
		next_res = res;
		next_idx = idx;
		next_prev_hi = prev_hi;
		next_prev_lo = prev_lo;
		next_oor = oor & rail_watch_en;
		next_shut = 11'h000;
		next_man_lo = conv_result_low;
		next_man_hi = conv_result_high;
		next_conv_ready = 1'b0;
		if (event_clear)
			next_idx = '0;
		if (busy && adc_done) begin
			next_busy = 1'b0;
			if (!busy_auto) begin
				{next_man_hi, next_man_lo} = adc_data;
				next_conv_ready = 1'b1;
			end else if (meas_mode) begin
				next_res[busy_ch] = v;
				next_idx[busy_ch] = busy_loc + 3'h1;
				meas_done = 1'b1;
			end else if (mode == rvm_pkg::RVM_SUPERVISE && !blanked[g]) begin
				next_prev_hi[g] = hi;
				next_prev_lo[g] = lo;
				next_oor[g] = hi || lo;
				fail = (hi && (!window_debounce_sel || prev_hi[g]))
					|| (lo && (!window_debounce_sel || prev_lo[g]));
				if (fail) begin
					next_res[busy_ch] = v;
					next_idx[busy_ch] = busy_loc + 3'h1;
					if (!rail_window_irq_mask || !fail_reset_select)
						next_shut[g] = 1'b1;
				end
			end
		end
		ev_set = fail || (mode == rvm_pkg::RVM_MEAS_ONLY && meas_done)
			|| (mode == rvm_pkg::RVM_BURST && slot == rvm_pkg::SLOT_A10 && slot_end
			&& active);
		next_event = ev_set || (rail_window_event && !event_clear);
		if (fail && rail_window_irq_mask && fail_reset_select) begin
			next_rst_cnt = RST_HOLD_CYC[rvm_pkg::RST_CNT_W-1:0];
			next_rst_hold = 1'b1;
		end else begin
			next_rst_cnt = rst_cnt != '0 ? rst_cnt - 1'b1 : rst_cnt;
			next_rst_hold = rst_hold && (rst_cnt != '0 || |(oor & elig));
		end
		next_good = mode == rvm_pkg::RVM_SUPERVISE && (rail_watch_en & ~rail_on) == 11'h000
			&& (next_oor & rail_watch_en) == 11'h000;
		next_fb2 = next_good && rail_window_irq_mask && fb2_good_sel;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			slot_cyc <= 10'h000;
			slot <= 4'h0;
			seq <= 4'h0;
			busy <= 1'b0;
			busy_auto <= 1'b0;
			busy_ch <= 2'h0;
			busy_loc <= 3'h0;
			ptr <= '0;
			man_pend <= 1'b0;
			adc_start <= 1'b0;
			adc_chan <= 4'h0;
			adc_rail <= 4'h0;
			res <= {3{rvm_pkg::RES_RST}};
			idx <= {3{rvm_pkg::IDX_RST}};
			prev_hi <= 11'h000;
			prev_lo <= 11'h000;
			oor <= 11'h000;
			rail_on_q <= 11'h000;
			rail_shutdown <= 11'h000;
			rail_window_event <= 1'b0;
			rst_cnt <= '0;
			rst_hold <= 1'b0;
			rails_good_flag <= 1'b0;
			feedback_pin_two <= 1'b0;
			conv_result_low <= 2'h0;
			conv_result_high <= 8'h00;
			conv_ready <= 1'b0;
		end else if (clk_en) begin
			slot_cyc <= next_slot_cyc;
			slot <= next_slot;
			seq <= next_seq;
			busy <= next_busy;
			busy_auto <= next_busy_auto;
			busy_ch <= next_busy_ch;
			busy_loc <= next_busy_loc;
			ptr <= next_ptr;
			man_pend <= next_man_pend;
			adc_start <= next_adc_start;
			adc_chan <= next_adc_chan;
			adc_rail <= next_adc_rail;
			res <= next_res;
			idx <= next_idx;
			prev_hi <= next_prev_hi;
			prev_lo <= next_prev_lo;
			oor <= next_oor;
			rail_on_q <= rail_on;
			rail_shutdown <= next_shut;
			rail_window_event <= next_event;
			rst_cnt <= next_rst_cnt;
			rst_hold <= next_rst_hold;
			rails_good_flag <= next_good;
			feedback_pin_two <= next_fb2;
			conv_result_low <= next_man_lo;
			conv_result_high <= next_man_hi;
			conv_ready <= next_conv_ready;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_event_set_wins: assert property (clk_en && ev_set |=> rail_window_event)
		else $error("event set lost");
	a_irq_follows: assert property ((clk_en && ev_set ##1 !rail_window_irq_mask)
		|-> !irq_out_n)
		else $error("interrupt not raised");
	a_meas_no_shut: assert property (clk_en && meas_mode |=> rail_shutdown == 11'h000)
		else $error("shutdown in measurement mode");
	a_reset_min_hold: assert property ($fell(system_reset_out_n)
		|-> !system_reset_out_n [*8])
		else $error("reset released early");
	a_reset_counter: assert property (rst_cnt != '0 |-> !system_reset_out_n)
		else $error("reset high while hold counts");
	a_index_clear: assert property (clk_en && event_clear && !(busy && adc_done)
		|=> idx == '0)
		else $error("index not cleared");
	a_slot_wrap: assert property (clk_en && slot_end && slot == rvm_pkg::SLOT_LAST
		|=> slot == 4'h0)
		else $error("slot sequence broken");
	a_result_msbs: assert property (clk_en && busy && busy_auto && adc_done && meas_mode
		&& busy_ch == 2'd0 |=> {chan8_watch_result, 2'h0} == ($past(adc_data) & 10'h3FC))
		else $error("result not eight MSBs");
	a_pause_auto: assert property (clk_en && paused && slot_start |=> !busy_auto
		|| !adc_start)
		else $error("measurement not paused");
	a_good_off: assert property (clk_en && (rail_watch_en & ~rail_on) != 11'h000
		|=> !rails_good_flag)
		else $error("power-good with disabled rail");
endmodule
